/* verilog/sc_pkg.sv */
/*
  Constants, types and the ratio decoder for the strap configuration block.
  Assumes a 25 MHz pclk and an APB slave with 32-bit data.
*/
`default_nettype none

package sc_pkg;

  // Register byte offsets
  localparam logic [11:0] SC_OFS_STATUS  = 12'h000;
  localparam logic [11:0] SC_OFS_CONTROL = 12'h004;

  // Status field positions
  localparam int SC_ST_CODE   = 0;
  localparam int SC_ST_HALVES = 4;
  localparam int SC_ST_VCO    = 8;
  localparam int SC_ST_BYPASS = 12;
  localparam int SC_ST_OFF    = 13;
  localparam int SC_ST_HYST   = 14;
  localparam int SC_ST_CTOE   = 15;
  localparam int SC_ST_FAST   = 16;
  localparam int SC_ST_VALID  = 17;

  // Control field position and reset value
  localparam int   SC_CT_GATE = 0;
  localparam logic SC_RST_GATE = 1'b1;

  // Reset values of the captured straps
  localparam logic [3:0] SC_RST_RATIO  = 4'h3;
  localparam logic       SC_RST_IN_LVL = 1'b1;
  localparam logic       SC_RST_IN_AFT = 1'b1;
  localparam logic       SC_RST_OUT    = 1'b0;

  // Ratio select codes with a special meaning, and the two VCO multipliers
  localparam logic [3:0] SC_CODE_X8     = 4'h1;
  localparam logic [3:0] SC_CODE_BYPASS = 4'h3;
  localparam logic [3:0] SC_CODE_OFF    = 4'hf;
  localparam logic [3:0] SC_VCO_X2      = 4'h2;
  localparam logic [3:0] SC_VCO_X8      = 4'h8;

  // Settle time after hard reset release
  localparam int SC_CLK_MHZ   = 25;
  localparam int SC_SETTLE_NS = 200;
  localparam int SC_SETTLE_CYC =
    (SC_SETTLE_NS * SC_CLK_MHZ + 999) / 1000;

  // Capture sequence states
  typedef enum logic [1:0] {
    SC_RESET,
    SC_SETTLE,
    SC_HELD
  } sc_cap_t;

  // Core ratio in halves (upper nibble) and VCO multiplier
  function automatic logic [7:0] sc_ratio_f(input logic [3:0] c);
    case (c)
      4'h0: sc_ratio_f = {4'h2, SC_VCO_X2};
      4'h1: sc_ratio_f = {4'h2, SC_VCO_X8};
      4'hc: sc_ratio_f = {4'h3, SC_VCO_X2};
      4'h4: sc_ratio_f = {4'h4, SC_VCO_X2};
      4'h6: sc_ratio_f = {4'h5, SC_VCO_X2};
      4'h8: sc_ratio_f = {4'h6, SC_VCO_X2};
      4'he: sc_ratio_f = {4'h7, SC_VCO_X2};
      4'ha: sc_ratio_f = {4'h8, SC_VCO_X2};
      4'h7: sc_ratio_f = {4'h9, SC_VCO_X2};
      4'hb: sc_ratio_f = {4'ha, SC_VCO_X2};
      4'h9: sc_ratio_f = {4'hb, SC_VCO_X2};
      4'hd: sc_ratio_f = {4'hc, SC_VCO_X2};
      4'h5: sc_ratio_f = {4'hd, SC_VCO_X2};
      4'h2: sc_ratio_f = {4'he, SC_VCO_X2};
      4'h3: sc_ratio_f = {4'h2, 4'h0};
      default: sc_ratio_f = 8'h00;
    endcase
  endfunction : sc_ratio_f

endpackage : sc_pkg

`default_nettype wire

/* verilog/sc_strap_ctrl.sv */
/*
  Strap configuration block: synchronises the ratio select and the two
  mode straps, captures them around hard reset and decodes clock and I/O
  modes. Status and control sit behind an APB slave.
  Assumes straps are static board ties or wired to hard reset.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - Four-bit ratio select sets core and VCO frequency from bus clock.
// RQ2 - Codes 0000 and 0001 give 1:1; VCO times two or eight.
// RQ3 - Remaining codes decode to 1.5 up to 7, VCO times two.
// RQ4 - 0011 bypasses PLL at 1:1; 1111 stops the internal clock.
// RQ5 - Board must not strap codes giving unsupported frequencies.
// RQ6 - Input strap high: hysteresis off, clock test output driven.
// RQ7 - Input strap low: hysteresis on, clock test output floated.
// RQ8 - Input strap on hard reset: hysteresis on, test output driven.
// RQ9 - Input strap on inverse reset: hysteresis off, test output floated.
// RQ10 - Output strap low or on hard reset: fast output mode.
// RQ11 - Output strap high or on inverse reset: compatible output timing.
// RQ12 - Strap levels captured during hard reset, modes held afterwards.
module sc_strap_ctrl #(
  parameter int ADDR_W = 12
) (
  // APB clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Strap pins
  input  wire logic              hard_reset_n,
  input  wire logic [3:0]        ratio_select,
  input  wire logic              input_mode_strap,
  input  wire logic              output_mode_strap,
  // Decoded clock configuration
  output var  logic [3:0]        ratio_code,
  output var  logic [3:0]        core_ratio_halves,
  output var  logic [3:0]        vco_mult,
  output var  logic              pll_enable,
  output var  logic              pll_bypass,
  output var  logic              core_clock_off,
  // Decoded I/O modes
  output var  logic              hysteresis_on,
  output var  logic              fast_out_mode,
  output var  logic              clock_test_output,
  output var  logic              clock_test_output_oe,
  output var  logic              modes_valid
);
  import sc_pkg::*;

  localparam int NSYNC = 7;

  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] pins;
  logic [3:0]       ratio_s;
  logic             in_s;
  logic             out_s;
  logic             hrst_s;
  sc_cap_t          state;
  logic [3:0]       settle;
  logic [3:0]       cap_ratio;
  logic             lvl_in;
  logic             aft_in;
  logic             lvl_out;
  logic             gate;
  logic [7:0]       dec;
  logic             mapped;
  logic             setup;
  logic             wr_ctl;
  logic [31:0]      next_rdata;

  // Pins cross into pclk through two flops each
  assign pins = {hard_reset_n, output_mode_strap,
                 input_mode_strap, ratio_select};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign ratio_s = sync2[3:0];
  assign in_s    = sync2[4];
  assign out_s   = sync2[5];
  assign hrst_s  = sync2[6];

  // Capture sequence; a new hard reset always restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= SC_RESET;
      settle <= 4'h0;
    end else if (!hrst_s) begin
      state  <= SC_RESET;
      settle <= 4'h0;
    end else begin
      case (state)
        SC_RESET: begin
          state  <= SC_SETTLE;
          settle <= 4'h0;
        end
        SC_SETTLE: begin
          settle <= settle + 4'h1;
          if (settle == 4'(SC_SETTLE_CYC - 1)) begin
            state <= SC_HELD;
          end
        end
        SC_HELD: state <= SC_HELD;
        default: state <= SC_RESET;
      endcase
    end
  end

  // Levels seen while hard reset is low; both sync paths match in delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ratio <= SC_RST_RATIO;
      lvl_in    <= SC_RST_IN_LVL;
      lvl_out   <= SC_RST_OUT;
    end else if (!hrst_s) begin
      cap_ratio <= ratio_s; // RQ1
      lvl_in    <= in_s;    // RQ12
      lvl_out   <= out_s;   // RQ12
    end
  end

  // Input strap level once the release has settled tells reset wiring apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aft_in <= SC_RST_IN_AFT;
    end else if (state == SC_SETTLE &&
                 settle == 4'(SC_SETTLE_CYC - 1)) begin
      aft_in <= in_s; // RQ12
    end
  end

  assign dec = sc_ratio_f(cap_ratio);

  // Clock configuration outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_code        <= SC_RST_RATIO;
      core_ratio_halves <= 4'h0;
      vco_mult          <= 4'h0;
      pll_enable        <= 1'b0;
      pll_bypass        <= 1'b0;
      core_clock_off    <= 1'b0;
    end else begin
      ratio_code        <= cap_ratio;  // RQ1
      core_ratio_halves <= dec[7:4];   // RQ2 RQ3
      vco_mult          <= dec[3:0];   // RQ2 RQ3
      pll_bypass        <= cap_ratio == SC_CODE_BYPASS; // RQ4
      core_clock_off    <= cap_ratio == SC_CODE_OFF;    // RQ4
      pll_enable        <= cap_ratio != SC_CODE_BYPASS &&
                           cap_ratio != SC_CODE_OFF;    // RQ4
    end
  end

  // I/O modes: low during reset means hysteresis on or fast out,
  // high after release means the test clock is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hysteresis_on        <= 1'b0;
      fast_out_mode        <= 1'b0;
      clock_test_output_oe <= 1'b0;
      modes_valid          <= 1'b0;
    end else begin
      hysteresis_on        <= !lvl_in;       // RQ6 RQ7 RQ8 RQ9
      clock_test_output_oe <= aft_in && gate; // RQ6 RQ7 RQ8 RQ9
      fast_out_mode        <= !lvl_out;      // RQ10 RQ11
      modes_valid          <= state == SC_HELD;
    end
  end

  // Test clock is pclk halved so it stays visible on a slow pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_test_output <= 1'b0;
    end else begin
      clock_test_output <= !clock_test_output;
    end
  end

  // APB decode; zero wait states
  assign mapped  = paddr[11:0] == SC_OFS_STATUS ||
                   paddr[11:0] == SC_OFS_CONTROL;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_ctl  = psel && penable && pwrite &&
                   paddr[11:0] == SC_OFS_CONTROL;

  // Control register: software can float the test clock regardless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= SC_RST_GATE;
    end else if (wr_ctl) begin
      gate <= pwdata[SC_CT_GATE];
    end
  end

  // Read mux, loaded in the setup phase so data is stable when sampled
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (paddr[11:0] == SC_OFS_STATUS) begin
      next_rdata[SC_ST_CODE +: 4]   = ratio_code;
      next_rdata[SC_ST_HALVES +: 4] = core_ratio_halves;
      next_rdata[SC_ST_VCO +: 4]    = vco_mult;
      next_rdata[SC_ST_BYPASS]      = pll_bypass;
      next_rdata[SC_ST_OFF]         = core_clock_off;
      next_rdata[SC_ST_HYST]        = hysteresis_on;
      next_rdata[SC_ST_CTOE]        = clock_test_output_oe;
      next_rdata[SC_ST_FAST]        = fast_out_mode;
      next_rdata[SC_ST_VALID]       = modes_valid;
    end else if (paddr[11:0] == SC_OFS_CONTROL) begin
      next_rdata[SC_CT_GATE] = gate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Checks
  a_ratio_stable: assert property ( // RQ1
    @(posedge pclk) disable iff (!presetn)
    state == SC_HELD && $past(state == SC_HELD, 2)
      |-> $stable(ratio_code))
    else $error("ratio changed after capture");

  a_code_x8: assert property ( // RQ2
    @(posedge pclk) disable iff (!presetn)
    cap_ratio == SC_CODE_X8 ##1 cap_ratio == SC_CODE_X8
      |-> vco_mult == 4'h8 && core_ratio_halves == 4'h2)
    else $error("code one must be 1:1 with x8");

  a_code_x2: assert property ( // RQ3
    @(posedge pclk) disable iff (!presetn)
    $past(cap_ratio == 4'hc) && pll_enable
      |-> core_ratio_halves == 4'h3 && vco_mult == 4'h2)
    else $error("code 1100 must be 1.5 with x2");

  a_seven: assert property ( // RQ3
    @(posedge pclk) disable iff (!presetn)
    $past(cap_ratio == 4'h2) |-> core_ratio_halves == 4'he)
    else $error("code 0010 must be 7");

  a_bypass: assert property ( // RQ4
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(cap_ratio == SC_CODE_BYPASS)
      |-> pll_bypass && !pll_enable && core_ratio_halves == 4'h2)
    else $error("bypass must disable PLL at 1:1");

  a_clock_off: assert property ( // RQ4
    @(posedge pclk) disable iff (!presetn)
    $past(cap_ratio == SC_CODE_OFF)
      |-> core_clock_off && !pll_enable && !pll_bypass)
    else $error("clock off code not decoded");

  a_tie_high: assert property ( // RQ6
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(lvl_in && aft_in && gate)
      |-> !hysteresis_on && clock_test_output_oe)
    else $error("high tie must be hyst off, driven");

  a_tie_low: assert property ( // RQ7
    @(posedge pclk) disable iff (!presetn)
    $past(!lvl_in && !aft_in)
      |-> hysteresis_on && !clock_test_output_oe)
    else $error("low tie must be hyst on, floated");

  a_on_reset: assert property ( // RQ8
    @(posedge pclk) disable iff (!presetn)
    $past(!lvl_in && aft_in && gate)
      |-> hysteresis_on && clock_test_output_oe)
    else $error("reset wiring must be hyst on, driven");

  a_inv_reset: assert property ( // RQ9
    @(posedge pclk) disable iff (!presetn)
    $past(lvl_in && !aft_in)
      |-> !hysteresis_on && !clock_test_output_oe)
    else $error("inverse wiring must be hyst off, floated");

  a_fast_mode: assert property ( // RQ10
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(!lvl_out) |-> fast_out_mode)
    else $error("low output strap must give fast out");

  a_compat: assert property ( // RQ11
    @(posedge pclk) disable iff (!presetn)
    $past(lvl_out) |-> !fast_out_mode)
    else $error("high output strap must give compatible");

  a_modes_held: assert property ( // RQ12
    @(posedge pclk) disable iff (!presetn)
    state == SC_HELD [*3]
      |-> $stable(hysteresis_on) && $stable(fast_out_mode))
    else $error("modes changed after reset release");

  a_apb_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !mapped |-> pslverr && pready)
    else $error("unmapped access must error");

endmodule : sc_strap_ctrl

`default_nettype wire

/* tb/sc_board_model.sv */
/*
  Board strapping and system reset model for the strap block.
  Assumes the bench picks one wiring for each mode strap and a ratio tie.
*/
`timescale 1ns/1ps
`default_nettype none

module sc_board_model (
  // Bench control
  input  wire logic       hold_reset,
  input  wire logic [3:0] ratio,
  input  wire logic [1:0] in_wire,
  input  wire logic [1:0] out_wire,
  // Strap pins
  output logic            hard_reset_n,
  output logic [3:0]      ratio_select,
  output logic            input_mode_strap,
  output logic            output_mode_strap
);
  // Wiring codes: 0 rail, 1 ground, 2 hard reset, 3 inverted hard reset
  function automatic logic wired(input logic [1:0] w, input logic rn);
    case (w)
      2'h0: wired = 1'b1;
      2'h1: wired = 1'b0;
      2'h2: wired = rn;
      default: wired = ~rn;
    endcase
  endfunction : wired

  // Reset is a plain level; the bench changes it just after an edge
  assign hard_reset_n      = ~hold_reset;
  // Ratio tie is static; frequency limits are the board's business
  assign ratio_select      = ratio;
  assign input_mode_strap  = wired(in_wire, hard_reset_n);
  assign output_mode_strap = wired(out_wire, hard_reset_n);
endmodule : sc_board_model

`default_nettype wire

/* tb/tb_sc_strap_ctrl.sv */
/*
  Self-checking bench: every ratio code once, its low and high bits picking
  the input and output strap wiring, then a few register bus probes.
  Assumes the board model drives the strap pins and pready needs no limit.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sc_strap_ctrl;
  import sc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, hold_reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic [3:0]  ratio = 4'h0;
  logic [1:0]  in_w = 2'h0, out_w = 2'h0;
  wire logic   hrn, ims, oms, pll_en, byp, off, hyst, fast, cto, oe, valid;
  wire logic [3:0] rsel, code, halves, vco;
  int          num_errors = 0, samples_checked = 0, seed = 32'h1a93;
  logic [17:0] notes[$];
  logic [17:0] last;
  event        recheck;
  // Core ratio in halves, indexed by ratio select code
  localparam logic [3:0] HALVES [16] = '{4'h2, 4'h2, 4'he, 4'h2, 4'h4, 4'hd, 4'h5, 4'h9,
                                         4'h6, 4'hb, 4'h8, 4'ha, 4'h3, 4'hc, 4'h7, 4'h0};

  always #20 pclk = ~pclk;

  sc_strap_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hard_reset_n(hrn), .ratio_select(rsel), .input_mode_strap(ims), .output_mode_strap(oms),
    .ratio_code(code), .core_ratio_halves(halves), .vco_mult(vco), .pll_enable(pll_en),
    .pll_bypass(byp), .core_clock_off(off), .hysteresis_on(hyst), .fast_out_mode(fast),
    .clock_test_output(cto), .clock_test_output_oe(oe), .modes_valid(valid));

  sc_board_model brd (.hold_reset(hold_reset), .ratio(ratio), .in_wire(in_w), .out_wire(out_w),
    .hard_reset_n(hrn), .ratio_select(rsel), .input_mode_strap(ims), .output_mode_strap(oms));

  // Expected status word; strap level during reset and after release differ
  function automatic logic [17:0] expect_word(input logic [3:0] c, input logic [1:0] iw, ow);
    logic [3:0] v;
    v = (c == 4'h1) ? 4'h8 : ((c == 4'h3 || c == 4'hf) ? 4'h0 : 4'h2);
    expect_word = {1'b1, (ow == 2'h1 || ow == 2'h2), (iw == 2'h0 || iw == 2'h2), (iw == 2'h1 || iw == 2'h2),
                   c == 4'hf, c == 4'h3, v, HALVES[c], c};
  endfunction : expect_word

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; entered after an edge, request held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // Watcher: outputs settle one cycle after the capture completes
  initial begin
    logic [17:0] n;
    logic        c0;
    forever begin
      @(posedge valid or recheck);
      @(posedge pclk);
      #1;
      n = notes.pop_front();
      check("ratio fields", {18'h0, off, byp, vco, halves, code}, {18'h0, n[13:0]});
      check("pll enable", {31'h0, pll_en}, {31'h0, ~(n[13] | n[12])});
      check("io modes", {28'h0, valid, fast, oe, hyst}, {28'h0, n[17:14]});
      // Test clock must keep toggling whether or not the pad drives it
      c0 = cto;
      @(posedge pclk);
      #1;
      check("test clock toggles", {31'h0, cto}, {31'h0, ~c0});
    end
  end

  // Watchdog at 6000 cycles, well beyond the few dozen cycles expected per code
  initial begin
    #(40 * 6000);
    num_errors++;
    print_verdict();
  end

  // Main sequence; the last pass captures rail wiring so the test output is on
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SC_OFS_CONTROL, 32'h0);
    check("control reset", rd, 32'h1);
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      hold_reset <= 1'b1;
      ratio      <= i[3:0];
      in_w       <= i[1:0];
      out_w      <= i[3:2];
      repeat (8) @(posedge pclk);
      last = expect_word(i[3:0], i[1:0], i[3:2]);
      notes.push_back(last);
      hold_reset <= 1'b0;
      wait (notes.size() == 0);
      // Straps wander after capture; the held modes must not follow
      repeat (8) begin
        @(posedge pclk);
        ratio <= 4'($random(seed));
        in_w  <= 2'($random(seed));
        out_w <= 2'($random(seed));
      end
      notes.push_back(last);
      ->recheck;
      wait (notes.size() == 0);
    end
    apb(1'b0, SC_OFS_STATUS, 32'h0);
    check("status read", rd, {14'h0, last});
    check("mapped no error", {31'h0, err}, 32'h0);
    apb(1'b1, SC_OFS_STATUS, 32'hffffffff);
    apb(1'b0, SC_OFS_STATUS, 32'h0);
    check("status after write", rd, {14'h0, last});
    apb(1'b1, SC_OFS_CONTROL, 32'h0);
    repeat (4) @(posedge pclk);
    check("gated test output", {31'h0, oe}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    print_verdict();
  end
endmodule : tb_sc_strap_ctrl

`default_nettype wire
